// ==== src/urm_pkg.sv ====
/*
 * constants of the uart host register map and receiver watchdog.
 * assumes one clock (mclk) and a synchronous active-high reset.
 */
package urm_pkg;
   // register offsets on the 4-bit host address
   localparam logic [3:0] ADR_MODE  = 4'h0;
   localparam logic [3:0] ADR_STAT  = 4'h1;
   localparam logic [3:0] ADR_CMD   = 4'h2;
   localparam logic [3:0] ADR_HOLD  = 4'h3;
   localparam logic [3:0] ADR_CHG   = 4'h4;
   localparam logic [3:0] ADR_INT   = 4'h5;
   localparam logic [3:0] ADR_CNT_HI = 4'h6;
   localparam logic [3:0] ADR_CNT_LO = 4'h7;
   localparam logic [3:0] ADR_GP    = 4'hC;
   localparam logic [3:0] ADR_PIN   = 4'hD;
   localparam logic [3:0] ADR_START = 4'hE;
   localparam logic [3:0] ADR_STOP  = 4'hF;
   // command word fields
   localparam logic [3:0] CMD_PTR_ONE  = 4'h1;
   localparam logic [3:0] CMD_PTR_ZERO = 4'hB;
   localparam int         CMD_RX_EN    = 0;
   localparam int         CMD_RX_DIS   = 1;
   localparam int         CMD_TX_EN    = 2;
   localparam int         CMD_TX_DIS   = 3;
   // mode register zero fields
   localparam int         MODE0_WDOG   = 7;
   // reset value and read value of unmapped offsets
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [7:0] RD_UNMAPPED  = 8'h00;
   // watchdog span in receiver 1x bit periods
   localparam logic [6:0] WDOG_BITS    = 7'h40;
   // mode register pointer
   typedef enum logic [1:0] {PTR_MODE0, PTR_MODE1, PTR_MODE2} urm_ptr_t;
endpackage

// ==== src/urm_regmap.sv ====
/*
 * host register map of a single-channel uart with mode register pointer,
 * command decode and receiver watchdog.
 * assumes host strobes and addresses synchronous to mclk, one access per
 * strobe assertion; the serial engines and counter live outside.
 */
// Operation
// - mode registers share one address via pointer
// - command low nibble enables or disables rx/tx
// - command B moves pointer to zero
// - registers honour read-only or write-only access
// - mode zero bit 7 enables watchdog
// - interrupt after 64 idle bit times with data
// - each mode access advances pointer, stops at two
// - reset points pointer at mode register one
// - fifo access restarts watchdog; empty means idle
`timescale 1ns/100ps
module urm_regmap
   import urm_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // host bus
   input  wire logic [3:0] addr,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_n,
   // read-only sources
   input  wire logic [7:0] status_in,
   input  wire logic [7:0] rx_data_in,
   input  wire logic [7:0] chg_flags_in,
   input  wire logic [7:0] int_status_in,
   input  wire logic [7:0] ctr_upper_in,
   input  wire logic [7:0] ctr_lower_in,
   input  wire logic [7:0] pin_state_in,
   // receive fifo and bit clock
   input  wire logic       rx_fifo_nonempty,
   input  wire logic       rx_fifo_wr,
   input  wire logic       rx_bit_tick,
   // configuration out
   output logic      [7:0] mode_zero,
   output logic      [7:0] mode_one,
   output logic      [7:0] mode_two,
   output logic      [7:0] clock_select,
   output logic      [7:0] aux_control,
   output logic      [7:0] interrupt_mask,
   output logic      [7:0] preset_upper,
   output logic      [7:0] preset_lower,
   output logic      [7:0] pin_config,
   output logic      [7:0] out_port,
   output logic      [7:0] vector_gp,
   output logic            rx_enable,
   output logic            tx_enable,
   // strobes out
   output logic            cmd_strobe,
   output logic      [7:0] cmd_code,
   output logic            tx_push,
   output logic      [7:0] tx_data,
   output logic            rx_pop,
   output logic            ct_start,
   output logic            ct_stop,
   output logic            wdog_irq
);
   logic       rd_prev_r, wr_prev_r;
   logic [7:0] mode_r [0:2];
   logic [7:0] cksel_r, aux_r, mask_r, prehi_r, prelo_r, pincf_r, opr_r, gp_r;
   logic [7:0] dout_r, dout_nxt, cmd_r, txd_r;
   logic       oe_n_r, rxen_r, rxen_nxt, txen_r, txen_nxt;
   logic       cmds_r, push_r, pop_r, start_r, stop_r, irq_r;
   logic [6:0] cnt_r, cnt_nxt;
   urm_ptr_t   ptr_r, ptr_nxt;
   // one access per strobe assertion
   wire rd_go = ~rd_n & rd_prev_r;
   wire wr_go = ~wr_n & wr_prev_r;
   wire rd_at [0:15];
   wire wr_at [0:15];
   genvar a;
   generate
      for (a = 0; a < 16; a++) begin : g_dec
         assign rd_at[a] = rd_go && (addr == 4'(a));
         assign wr_at[a] = wr_go && (addr == 4'(a));
      end
   endgenerate

   wire mode_acc  = rd_at[ADR_MODE] | wr_at[ADR_MODE];
   wire cmd_wr    = wr_at[ADR_CMD];
   wire [3:0] cop = data_in[7:4];
   wire wd_on     = mode_r[0][MODE0_WDOG];
   wire wd_kick   = rx_fifo_wr | rd_at[ADR_HOLD];
   always_comb begin
      ptr_nxt = ptr_r;
      if (cmd_wr && cop == CMD_PTR_ZERO)
         ptr_nxt = PTR_MODE0;
      else if (cmd_wr && cop == CMD_PTR_ONE)
         ptr_nxt = PTR_MODE1;
      else if (mode_acc) begin
         unique case (ptr_r)
            PTR_MODE0: ptr_nxt = PTR_MODE1;
            PTR_MODE1: ptr_nxt = PTR_MODE2;
            PTR_MODE2: ptr_nxt = PTR_MODE2;
            default:   ptr_nxt = PTR_MODE2;
         endcase
      end
   end

   always_comb begin
      rxen_nxt = rxen_r;
      txen_nxt = txen_r;
      if (cmd_wr) begin
         if (data_in[CMD_RX_DIS])
            rxen_nxt = 1'b0;
         else if (data_in[CMD_RX_EN])
            rxen_nxt = 1'b1;
         if (data_in[CMD_TX_DIS])
            txen_nxt = 1'b0;
         else if (data_in[CMD_TX_EN])
            txen_nxt = 1'b1;
      end
   end

   // read side only sees readable registers
   always_comb begin
      unique case (addr)
         ADR_MODE: dout_nxt = mode_r[ptr_r];
         ADR_STAT: dout_nxt = status_in;
         ADR_HOLD: dout_nxt = rx_data_in;
         ADR_CHG:  dout_nxt = chg_flags_in;
         ADR_INT:  dout_nxt = int_status_in;
         ADR_CNT_HI: dout_nxt = ctr_upper_in;
         ADR_CNT_LO: dout_nxt = ctr_lower_in;
         ADR_GP:   dout_nxt = gp_r;
         ADR_PIN:  dout_nxt = pin_state_in;
         default:  dout_nxt = RD_UNMAPPED;
      endcase
   end

   always_comb begin
      cnt_nxt = cnt_r;
      if (!wd_on || !rx_fifo_nonempty || wd_kick)
         cnt_nxt = 7'h00;
      else if (rx_bit_tick && cnt_r != WDOG_BITS)
         cnt_nxt = cnt_r + 7'h01;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_prev_r <= 1'b1;
         wr_prev_r <= 1'b1;
         ptr_r     <= PTR_MODE1;
         rxen_r    <= 1'b0;
         txen_r    <= 1'b0;
         cnt_r     <= 7'h00;
         irq_r     <= 1'b0;
      end else begin
         rd_prev_r <= rd_n;
         wr_prev_r <= wr_n;
         ptr_r     <= ptr_nxt;
         rxen_r    <= rxen_nxt;
         txen_r    <= txen_nxt;
         cnt_r     <= cnt_nxt;
         irq_r     <= wd_on && (cnt_nxt == WDOG_BITS);
      end
   end

   genvar m;
   generate
      for (m = 0; m < 3; m++) begin : g_mode
         always_ff @(posedge mclk) begin
            if (srst)
               mode_r[m] <= REG_RST;
            else if (wr_at[ADR_MODE] && ptr_r == urm_ptr_t'(m))
               mode_r[m] <= data_in;
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (srst) begin
         cksel_r <= REG_RST;
         aux_r   <= REG_RST;
         mask_r  <= REG_RST;
         prehi_r <= REG_RST;
         prelo_r <= REG_RST;
         pincf_r <= REG_RST;
         opr_r   <= REG_RST;
         gp_r    <= REG_RST;
      end else begin
         if (wr_at[ADR_STAT])   cksel_r <= data_in;
         if (wr_at[ADR_CHG])    aux_r   <= data_in;
         if (wr_at[ADR_INT])    mask_r  <= data_in;
         if (wr_at[ADR_CNT_HI]) prehi_r <= data_in;
         if (wr_at[ADR_CNT_LO]) prelo_r <= data_in;
         if (wr_at[ADR_PIN])    pincf_r <= data_in;
         if (wr_at[ADR_GP])    gp_r   <= data_in;
         if (wr_at[ADR_START])
            opr_r <= opr_r | data_in;
         else if (wr_at[ADR_STOP])
            opr_r <= opr_r & ~data_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         dout_r  <= REG_RST;
         oe_n_r  <= 1'b1;
         cmds_r  <= 1'b0;
         cmd_r   <= REG_RST;
         push_r  <= 1'b0;
         txd_r   <= REG_RST;
         pop_r   <= 1'b0;
         start_r <= 1'b0;
         stop_r  <= 1'b0;
      end else begin
         oe_n_r  <= rd_n;
         if (rd_go)
            dout_r <= dout_nxt;
         cmds_r  <= cmd_wr;
         if (cmd_wr)
            cmd_r <= data_in;
         push_r  <= wr_at[ADR_HOLD];
         if (wr_at[ADR_HOLD])
            txd_r <= data_in;
         pop_r   <= rd_at[ADR_HOLD];
         start_r <= rd_at[ADR_START];
         stop_r  <= rd_at[ADR_STOP];
      end
   end

   assign data_out       = dout_r;
   assign data_oe_n      = oe_n_r;
   assign mode_zero      = mode_r[0];
   assign mode_one       = mode_r[1];
   assign mode_two       = mode_r[2];
   assign clock_select   = cksel_r;
   assign aux_control    = aux_r;
   assign interrupt_mask = mask_r;
   assign preset_upper   = prehi_r;
   assign preset_lower   = prelo_r;
   assign pin_config     = pincf_r;
   assign out_port       = opr_r;
   assign vector_gp      = gp_r;
   assign rx_enable      = rxen_r;
   assign tx_enable      = txen_r;
   assign cmd_strobe     = cmds_r;
   assign cmd_code       = cmd_r;
   assign tx_push        = push_r;
   assign tx_data        = txd_r;
   assign rx_pop         = pop_r;
   assign ct_start       = start_r;
   assign ct_stop        = stop_r;
   assign wdog_irq       = irq_r;
   property p_ptr_rst;
      @(posedge mclk) srst |=> ptr_r == PTR_MODE1;
   endproperty
   a_ptr_rst: assert property (p_ptr_rst)
      else $error("pointer not at one after reset");

   property p_ptr_zero;
      @(posedge mclk) disable iff (srst)
      cmd_wr && cop == CMD_PTR_ZERO |=> ptr_r == PTR_MODE0;
   endproperty
   a_ptr_zero: assert property (p_ptr_zero)
      else $error("command B did not move pointer to zero");

   property p_ptr_one;
      @(posedge mclk) disable iff (srst)
      cmd_wr && cop == CMD_PTR_ONE |=> ptr_r == PTR_MODE1;
   endproperty
   a_ptr_one: assert property (p_ptr_one)
      else $error("command 1 did not select mode one");

   property p_ptr_adv;
      @(posedge mclk) disable iff (srst)
      mode_acc && !cmd_wr && ptr_r != PTR_MODE0 |=> ptr_r == PTR_MODE2;
   endproperty
   a_ptr_adv: assert property (p_ptr_adv)
      else $error("pointer did not settle on mode two");

   property p_nibble;
      @(posedge mclk) disable iff (srst)
      cmd_wr && data_in[CMD_RX_EN] && !data_in[CMD_RX_DIS]
         && data_in[CMD_TX_DIS] |=> rx_enable && !tx_enable;
   endproperty
   a_nibble: assert property (p_nibble)
      else $error("enable nibble not applied");

   property p_ro_wo;
      @(posedge mclk) disable iff (srst)
      rd_at[ADR_CMD] |=> data_out == RD_UNMAPPED && $stable(cmd_code);
   endproperty
   a_ro_wo: assert property (p_ro_wo)
      else $error("write-only register leaked on read");

   property p_dir;
      @(posedge mclk) disable iff (srst)
      wr_at[ADR_HOLD] |=> tx_push && !rx_pop;
   endproperty
   a_dir: assert property (p_dir)
      else $error("write to holding offset misrouted");

   property p_wd_off;
      @(posedge mclk) disable iff (srst)
      !wd_on |=> !wdog_irq;
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("watchdog fired while disabled");

   property p_wd_fire;
      @(posedge mclk) disable iff (srst)
      $rose(wdog_irq) |-> $past(cnt_r) == WDOG_BITS - 7'h01
         && $past(rx_bit_tick);
   endproperty
   a_wd_fire: assert property (p_wd_fire)
      else $error("watchdog fired at wrong count");

   property p_wd_idle;
      @(posedge mclk) disable iff (srst)
      !rx_fifo_nonempty || wd_kick |=> !wdog_irq && cnt_r == 7'h00;
   endproperty
   a_wd_idle: assert property (p_wd_idle)
      else $error("watchdog not restarted or active when empty");
endmodule

// ==== tb/urm_host.sv ====
/* host processor model: one read or write per strobe.
   assumes mclk from the bench; outputs change just after the edge. */
`timescale 1ns/100ps
module urm_host (
   // clock
   input  wire logic       mclk,
   // host bus
   output logic      [3:0] addr,
   output logic            rd_n,
   output logic            wr_n,
   output logic      [7:0] data_in,
   input  wire logic [7:0] data_out
);
   initial begin
      addr    = 4'h0;
      rd_n    = 1'h1;
      wr_n    = 1'h1;
      data_in = 8'h00;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr    <= a;
      data_in <= v;
      wr_n    <= 1'h0;
      @(posedge mclk);
      wr_n    <= 1'h1;
      data_in <= ~v;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd_n <= 1'h0;
      @(posedge mclk);
      @(posedge mclk);
      v = data_out;
      rd_n <= 1'h1;
   endtask
endmodule

// ==== tb/tb_top.sv ====
/* bench: register map against an integer model of pointer, map and
   watchdog. assumes the host model drives the bus. */
`timescale 1ns/100ps
module tb_top;
   import urm_pkg::*;
   logic        mclk, srst, rd_n, wr_n, oe_n, ne, fwr, tk;
   logic        rxe, txe, cst, txp, rxp, cts, ctp, irq;
   logic [3:0]  addr;
   logic [7:0]  din, dout, d, e, mz, m1, m2, cs, ax, im, pu, pl, pc;
   logic [7:0]  op, vg, cc, txd;
   logic [7:0]  src [7];
   logic [7:0]  wexp [11];
   logic [87:0] cfg;
   int          errors, checked, ptr;
   int          n [5] = '{default: 0};
   int          x [5] = '{default: 0};
   logic        ren, ten;
   assign cfg = {vg, op, pc, pl, pu, im, ax, cs, m2, m1, mz};

   urm_host i_urm_host (.mclk(mclk), .addr(addr), .rd_n(rd_n),
      .wr_n(wr_n), .data_in(din), .data_out(dout));
   urm_regmap i_urm_regmap (.mclk(mclk), .srst(srst), .addr(addr),
      .rd_n(rd_n), .wr_n(wr_n), .data_in(din), .data_out(dout),
      .data_oe_n(oe_n), .status_in(src[0]), .rx_data_in(src[1]),
      .chg_flags_in(src[2]), .int_status_in(src[3]),
      .ctr_upper_in(src[4]), .ctr_lower_in(src[5]),
      .pin_state_in(src[6]), .rx_fifo_nonempty(ne), .rx_fifo_wr(fwr),
      .rx_bit_tick(tk), .mode_zero(mz), .mode_one(m1), .mode_two(m2),
      .clock_select(cs), .aux_control(ax), .interrupt_mask(im),
      .preset_upper(pu), .preset_lower(pl), .pin_config(pc),
      .out_port(op), .vector_gp(vg), .rx_enable(rxe), .tx_enable(txe),
      .cmd_strobe(cst), .cmd_code(cc), .tx_push(txp), .tx_data(txd),
      .rx_pop(rxp), .ct_start(cts), .ct_stop(ctp), .wdog_irq(irq));

   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   // pulse counts: a held pulse counts once per cycle it stays high
   always @(posedge mclk) begin
      n[0] <= n[0] + (cst === 1'h1);
      n[1] <= n[1] + (txp === 1'h1);
      n[2] <= n[2] + (rxp === 1'h1);
      n[3] <= n[3] + (cts === 1'h1);
      n[4] <= n[4] + (ctp === 1'h1);
   end

   task automatic chk(input string s, input logic [7:0] ex,
                      input logic [7:0] got);
      checked++;
      if (got !== ex) begin
         errors++;
         $display("unexpected %s expected %h seen %h", s, ex, got);
      end
   endtask
   task automatic chkb(input string s, input logic ex, input logic got);
      checked++;
      if (got !== ex) begin
         errors++;
         $display("unexpected %s expected %b seen %b", s, ex, got);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic w(input logic [3:0] a, input logic [7:0] v);
      i_urm_host.wr(a, v);
      #1;
      case (a)
         ADR_MODE: begin
            wexp[ptr] = v;
            if (ptr < 2) ptr++;
         end
         ADR_CMD: begin
            x[0]++;
            if (v[7:4] == CMD_PTR_ONE) ptr = 1;
            if (v[7:4] == CMD_PTR_ZERO) ptr = 0;
            ren = v[CMD_RX_DIS] ? 1'h0 : (v[CMD_RX_EN] ? 1'h1 : ren);
            ten = v[CMD_TX_DIS] ? 1'h0 : (v[CMD_TX_EN] ? 1'h1 : ten);
            chk("cmd_code", v, cc);
            chkb("rx_enable", ren, rxe);
            chkb("tx_enable", ten, txe);
         end
         ADR_HOLD: begin
            x[1]++;
            chk("tx_data", v, txd);
         end
         ADR_STAT: wexp[3] = v;
         ADR_CHG: wexp[4] = v;
         ADR_INT: wexp[5] = v;
         ADR_CNT_HI: wexp[6] = v;
         ADR_CNT_LO: wexp[7] = v;
         ADR_PIN: wexp[8] = v;
         ADR_START: wexp[9] = wexp[9] | v;
         ADR_STOP: wexp[9] = wexp[9] & ~v;
         ADR_GP: wexp[10] = v;
         default: ;
      endcase
      for (int i = 0; i < 11; i++)
         chk("config_reg", wexp[i], cfg[8*i +: 8]);
   endtask

   task automatic r(input logic [3:0] a);
      i_urm_host.rd(a, d);
      #1;
      case (a)
         ADR_MODE: e = wexp[ptr];
         ADR_STAT: e = src[0];
         ADR_HOLD: e = src[1];
         ADR_CHG: e = src[2];
         ADR_INT: e = src[3];
         ADR_CNT_HI: e = src[4];
         ADR_CNT_LO: e = src[5];
         ADR_PIN: e = src[6];
         ADR_GP: e = wexp[10];
         default: e = RD_UNMAPPED;
      endcase
      if (a == ADR_MODE && ptr < 2) ptr++;
      x[2] += (a == ADR_HOLD);
      x[3] += (a == ADR_START);
      x[4] += (a == ADR_STOP);
      chk("read_data", e, d);
      chkb("data_oe_n", 1'h0, oe_n);
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge mclk) tk <= 1'h1;
         @(posedge mclk) tk <= 1'h0;
      end
      #1;
   endtask

   initial begin
      #200000;
      errors++;
      give_verdict();
   end

   initial begin
      srst = 1'h1;
      ne = 1'h0;
      fwr = 1'h0;
      tk = 1'h0;
      ptr = 1;
      ren = 1'h0;
      ten = 1'h0;
      foreach (src[i]) src[i] = 8'h00;
      foreach (wexp[i]) wexp[i] = REG_RST;
      void'($urandom(13118));
      repeat (8) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      #1;
      for (int i = 0; i < 11; i++)
         chk("reset_reg", REG_RST, cfg[8*i +: 8]);
      chkb("data_oe_n", 1'h1, oe_n);
      $display("test reset done");
      repeat (3) w(ADR_MODE, 8'($urandom));
      for (int k = 0; k < 16; k++) begin
         w(ADR_CMD, {k[1:0] == 0 ? CMD_PTR_ONE : (k[1:0] == 1 ?
            CMD_PTR_ZERO : 4'($urandom)), 4'(k)});
         w(ADR_MODE, 8'($urandom));
         r(ADR_MODE);
      end
      $display("test pointer done");
      @(posedge mclk);
      foreach (src[i]) src[i] <= 8'($urandom);
      for (int a = 0; a < 16; a++) w(4'(a), 8'($urandom));
      for (int a = 0; a < 16; a++) r(4'(a));
      $display("test map done");
      @(posedge mclk) srst <= 1'h1;
      repeat (2) @(posedge mclk);
      srst <= 1'h0;
      ptr = 1;
      ren = 1'h0;
      ten = 1'h0;
      foreach (wexp[i]) wexp[i] = REG_RST;
      w(ADR_MODE, 8'($urandom));
      $display("test mid-run reset done");
      @(posedge mclk) ne <= 1'h1;
      w(ADR_CMD, {CMD_PTR_ZERO, 4'h0});
      w(ADR_MODE, 8'h80);
      tick(63);
      chkb("wdog_irq", 1'h0, irq);
      tick(1);
      chkb("wdog_irq", 1'h1, irq);
      @(posedge mclk) fwr <= 1'h1;
      @(posedge mclk) fwr <= 1'h0;
      @(posedge mclk) #1;
      chkb("wdog_irq", 1'h0, irq);
      tick(63);
      chkb("wdog_irq", 1'h0, irq);
      tick(1);
      chkb("wdog_irq", 1'h1, irq);
      r(ADR_HOLD);
      chkb("wdog_irq", 1'h0, irq);
      tick(64);
      chkb("wdog_irq", 1'h1, irq);
      @(posedge mclk) ne <= 1'h0;
      tick(70);
      chkb("wdog_irq", 1'h0, irq);
      @(posedge mclk) ne <= 1'h1;
      w(ADR_CMD, {CMD_PTR_ZERO, 4'h0});
      w(ADR_MODE, 8'h00);
      tick(70);
      chkb("wdog_irq", 1'h0, irq);
      $display("test watchdog done");
      for (int i = 0; i < 5; i++)
         chk("pulse_count", 8'(x[i]), 8'(n[i]));
      give_verdict();
   end
endmodule
